// *** design/core_irq_pkg.sv ***
// core interrupt control package: register map, field layout, reset values
// assumes a 32-bit apb slave with 12-bit byte addresses, word aligned
package core_irq_pkg;

   // register indices; the byte address is four times the index
   localparam logic [9:0] CTRL_IDX = 10'h00b;
   localparam logic [9:0] EVT_STAT_IDX = 10'h00c;
   localparam logic [9:0] EVT_MASK_IDX = 10'h00d;
   localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
   localparam logic [11:0] EVT_STAT_ADDR = {EVT_STAT_IDX, 2'h0};
   localparam logic [11:0] EVT_MASK_ADDR = {EVT_MASK_IDX, 2'h0};

   // field positions of the control register
   localparam int unsigned GIE_BIT = 7;
   localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int unsigned TMR_IE_BIT = 5;
   localparam int unsigned EXT_IE_BIT = 4;
   localparam int unsigned PORT_IE_BIT = 3;
   localparam int unsigned TMR_FLAG_BIT = 2;
   localparam int unsigned EXT_FLAG_BIT = 1;
   localparam int unsigned PORT_FLAG_BIT = 0;

   // field positions of the event status and mask registers
   localparam int unsigned EVT_TMR_BIT = 0;
   localparam int unsigned EVT_EXT_BIT = 1;
   localparam int unsigned EVT_PORT_BIT = 2;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] EVT_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam int unsigned PORT_W = 4;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic tmr_ie;
      logic ext_ie;
      logic port_ie;
      logic tmr_flag;
      logic ext_flag;
      logic port_flag;
   } ctrl_t;

   // one bit per core event source, bit 2 down to bit 0
   typedef struct packed {
      logic port_chg;
      logic ext_edge;
      logic tmr_ovf;
   } evt_t;

   // bus answer state
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ANSWER = 1'b1
   } bus_state_t;

endpackage : core_irq_pkg

// *** design/core_irq_ctrl.sv ***
// core interrupt control and status register with an apb slave front end
// assumes event inputs synchronous to i_clk_sys and a standard apb master
//
// Behaviour
// - flags set regardless of any enable
// - control register readable and writable over bus
// - global enable bit 7 gates all requests to o_core_irq; o_evt_irq is not gated by it
// - peripheral enable bit 6 gates peripheral requests
// - bit 5 enables timer overflow interrupt
// - bit 4 enables external pin interrupt
// - bit 3 enables port change interrupt
// - bit 2 timer flag, cleared only by software
// - bit 1 external pin flag, software clears
// - bit 0 set on upper port change
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module core_irq_ctrl
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // event sources
   input wire logic i_tmr_overflow,
   input wire logic i_ext_pin,
   input wire logic i_ext_rise_sel,
   input wire logic [core_irq_pkg::PORT_W-1:0] i_port_upper,
   input wire logic i_periph_req,
   // interrupt outputs
   output logic o_core_irq,
   output logic o_evt_irq,
   output core_irq_pkg::ctrl_t o_ctrl
);

   core_irq_pkg::ctrl_t ctrl_r;
   core_irq_pkg::ctrl_t ctrl_nxt;
   core_irq_pkg::evt_t evt_r;
   core_irq_pkg::evt_t evt_nxt;
   core_irq_pkg::evt_t mask_r;
   core_irq_pkg::evt_t ev;
   core_irq_pkg::bus_state_t state_r;
   logic ext_prev_r;
   logic [core_irq_pkg::PORT_W-1:0] port_prev_r;
   logic prev_valid_r;
   logic setup;
   logic acc;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic wr_ctrl;
   logic wr_mask;
   logic rd_stat;
   logic core_req;
   logic [31:0] rdata;

   // edge and change detection; previous samples are caught after release
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ext_prev_r <= 1'b0;
         port_prev_r <= '0;
         prev_valid_r <= 1'b0;
      end
      else
      begin
         ext_prev_r <= i_ext_pin;
         port_prev_r <= i_port_upper;
         prev_valid_r <= 1'b1;
      end
   end

   // source events; pin edge and port change masked off until the first sample is held, timer overflow is not
   always_comb
   begin
      ev.tmr_ovf = i_tmr_overflow;
      ev.ext_edge = prev_valid_r & (i_ext_rise_sel ? (i_ext_pin & ~ext_prev_r)
                                                  : (~i_ext_pin & ext_prev_r));
      ev.port_chg = prev_valid_r & (i_port_upper != port_prev_r);
   end

   // address decode; misaligned addresses fall into the unmapped answer
   assign hit_ctrl = (i_paddr == core_irq_pkg::CTRL_ADDR);
   assign hit_stat = (i_paddr == core_irq_pkg::EVT_STAT_ADDR);
   assign hit_mask = (i_paddr == core_irq_pkg::EVT_MASK_ADDR);
   assign setup = i_psel & ~i_penable;
   assign acc = (state_r == core_irq_pkg::ST_ANSWER) & i_psel & i_penable;
   assign wr_ctrl = acc & i_pwrite & hit_ctrl;
   assign wr_mask = acc & i_pwrite & hit_mask;
   assign rd_stat = acc & ~i_pwrite & hit_stat;

   // read mux; narrow registers sit in the low bits, the rest read zero
   always_comb
   begin
      rdata = 32'h0000_0000;
      if (hit_ctrl)
      begin
         rdata[7:0] = ctrl_r;
      end
      else if (hit_stat)
      begin
         rdata[2:0] = evt_r;
      end
      else if (hit_mask)
      begin
         rdata[2:0] = mask_r;
      end
   end

   // one wait-free answer: data is captured in setup, pready in access
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_r <= core_irq_pkg::ST_IDLE;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         case (state_r)
            core_irq_pkg::ST_IDLE:
            begin
               if (setup)
               begin
                  state_r <= core_irq_pkg::ST_ANSWER;
                  o_pready <= 1'b1;
                  o_pslverr <= ~(hit_ctrl | hit_stat | hit_mask);
                  o_prdata <= i_pwrite ? 32'h0000_0000 : rdata;
               end
            end
            core_irq_pkg::ST_ANSWER:
            begin
               // access ends here since pready is already high
               state_r <= core_irq_pkg::ST_IDLE;
               o_pready <= 1'b0;
               o_pslverr <= 1'b0;
               o_prdata <= 32'h0000_0000;
            end
            default:
            begin
               state_r <= core_irq_pkg::ST_IDLE;
               o_pready <= 1'b0;
               o_pslverr <= 1'b0;
               o_prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // next control value; an event in the write cycle beats a software clear
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
      begin
         ctrl_nxt = i_pwdata[7:0];
      end
      ctrl_nxt.tmr_flag = ctrl_nxt.tmr_flag | ev.tmr_ovf;
      // external pin flag set on edge
      ctrl_nxt.ext_flag = ctrl_nxt.ext_flag | ev.ext_edge;
      ctrl_nxt.port_flag = ctrl_nxt.port_flag | ev.port_chg;
   end

   // control register; the port flag powers up cleared rather than unknown
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctrl_r <= core_irq_pkg::CTRL_RST;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // sticky event status, cleared by reading it; new events survive the read
   always_comb
   begin
      evt_nxt = rd_stat ? core_irq_pkg::EVT_RST : evt_r;
      evt_nxt = evt_nxt | ev;
   end

   // event status and mask registers
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         evt_r <= core_irq_pkg::EVT_RST;
         mask_r <= core_irq_pkg::MASK_RST;
      end
      else
      begin
         evt_r <= evt_nxt;
         if (wr_mask)
         begin
            mask_r <= i_pwdata[2:0];
         end
      end
   end

   // request to the core from the current register contents and the peripheral request input
   always_comb
   begin
      core_req = ctrl_r.global_irq_enable & ((ctrl_r.tmr_ie & ctrl_r.tmr_flag)
                             | (ctrl_r.ext_ie & ctrl_r.ext_flag)
                             | (ctrl_r.port_ie & ctrl_r.port_flag)
                             | (ctrl_r.peripheral_irq_enable & i_periph_req));
   end

   // registered outputs so nothing reaches the pins through gates
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_core_irq <= 1'b0;
         o_evt_irq <= 1'b0;
         o_ctrl <= core_irq_pkg::CTRL_RST;
      end
      else
      begin
         o_core_irq <= core_req;
         o_evt_irq <= |(evt_nxt & mask_r);
         o_ctrl <= ctrl_nxt;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_setup;
      i_psel && !i_penable;
   endsequence

   sequence s_ctrl_write;
      (s_setup and (i_pwrite && hit_ctrl)) ##1 (i_psel && i_penable && o_pready);
   endsequence

   sequence s_stat_read_quiet;
      (s_setup and (!i_pwrite && hit_stat)) ##1 (i_psel && i_penable && o_pready && ev == 3'h0);
   endsequence

   chk_flag_any_enable: assert property (ev.tmr_ovf && !ctrl_r.global_irq_enable |=> ctrl_r.tmr_flag)
      else $error("timer flag not set while interrupts disabled");
   chk_ctrl_write: assert property (s_ctrl_write |=> ctrl_r[7:3] == $past(i_pwdata[7:3]))
      else $error("control enables not stored on write");
   chk_global_block: assert property (!ctrl_r.global_irq_enable |=> !o_core_irq)
      else $error("core request raised with global enable off");
   chk_periph_gate: assert property (ctrl_r.global_irq_enable && ctrl_r.peripheral_irq_enable && i_periph_req |=> o_core_irq)
      else $error("peripheral request not passed to core");
   chk_tmr_gate: assert property (!ctrl_r.peripheral_irq_enable && !ctrl_r.ext_ie && !ctrl_r.port_ie
      && ctrl_r.global_irq_enable && ctrl_r.tmr_flag |=> o_core_irq == $past(ctrl_r.tmr_ie))
      else $error("timer enable does not gate core request");
   chk_ext_gate: assert property (!ctrl_r.peripheral_irq_enable && !ctrl_r.tmr_ie && !ctrl_r.port_ie
      && ctrl_r.global_irq_enable && ctrl_r.ext_flag |=> o_core_irq == $past(ctrl_r.ext_ie))
      else $error("external enable does not gate core request");
   chk_port_gate: assert property (!ctrl_r.peripheral_irq_enable && !ctrl_r.tmr_ie && !ctrl_r.ext_ie
      && ctrl_r.global_irq_enable && ctrl_r.port_flag |=> o_core_irq == $past(ctrl_r.port_ie))
      else $error("port enable does not gate core request");
   chk_tmr_hold: assert property (ctrl_r.tmr_flag && !wr_ctrl |=> ctrl_r.tmr_flag)
      else $error("timer flag cleared without software");
   // a software write in the cycle after the set may legally clear the copy
   chk_ext_set: assert property (ev.ext_edge |=> ctrl_r.ext_flag
      ##1 (o_ctrl.ext_flag || $past(wr_ctrl)))
      else $error("external flag missed an edge");
   chk_port_set: assert property (prev_valid_r && i_port_upper != port_prev_r
      |=> ctrl_r.port_flag)
      else $error("port flag missed a change");
   chk_core_cause: assert property (o_core_irq |-> $past(ctrl_r.global_irq_enable))
      else $error("core request without global enable");
   chk_stat_rdclr: assert property (s_stat_read_quiet |=> evt_r == 3'h0)
      else $error("event status not cleared by read");
   chk_bus_answer: assert property ((s_setup and (state_r == core_irq_pkg::ST_IDLE))
      |=> o_pready ##1 !o_pready)
      else $error("bus answer not one cycle after setup");

endmodule : core_irq_ctrl

`default_nettype wire

// *** testbench/event_source_model.sv ***
// event source model: timer overflow pulse, external pin pulse, port bit 0 flip
// assumes the bench raises i_kick for one cycle, right after a rising edge
`timescale 1ns/1ns
`default_nettype none

module event_source_model
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // event requests: 0 timer, 1 pin, 2 port
   input wire logic [2:0] i_kick,
   // source lines toward the block
   output logic o_tmr_overflow,
   output logic o_ext_pin,
   output logic [core_irq_pkg::PORT_W-1:0] o_port_upper
);
   // source events
   // pin pulse gives one rise and one fall, so either polarity sees one edge
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_tmr_overflow <= 1'b0;
         o_ext_pin <= 1'b0;
         o_port_upper <= '0;
      end
      else
      begin
         o_tmr_overflow <= i_kick[0];
         o_ext_pin <= i_kick[1];
         o_port_upper[0] <= o_port_upper[0] ^ i_kick[2];
      end
   end
endmodule : event_source_model

`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the core interrupt control block over apb
// assumes zero-wait answers are possible but waits on pready, bounded
`timescale 1ns/1ns
`default_nettype none

module testbench;
   localparam logic [11:0] A_CTL = core_irq_pkg::CTRL_ADDR;
   localparam logic [11:0] A_STA = core_irq_pkg::EVT_STAT_ADDR;
   localparam logic [11:0] A_MSK = core_irq_pkg::EVT_MASK_ADDR;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tmr, ext, rise_sel, periph;
   logic core_irq, evt_irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] port;
   logic [2:0] kick;
   logic [7:0] ie, fl;
   logic [7:0] ctl;
   int miscompares = 0;
   int check_count = 0;

   core_irq_ctrl core_irq_ctrl_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tmr_overflow(tmr),
      .i_ext_pin(ext), .i_ext_rise_sel(rise_sel), .i_port_upper(port),
      .i_periph_req(periph), .o_core_irq(core_irq), .o_evt_irq(evt_irq), .o_ctrl(ctl));
   event_source_model event_source_model_inst (.i_clk_sys(clk), .i_arst_n(rst_n),
      .i_kick(kick), .o_tmr_overflow(tmr), .o_ext_pin(ext), .o_port_upper(port));

   // 25 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         miscompares++;
      end
   endtask : check

   // one apb transfer; pready and data are taken at the rising edge that ends it,
   // then one idle edge passes so a following call never reassigns psel at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         miscompares++;
         close_out();
      end
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
      check({31'h0, e}, 32'h0);
      if (a == A_CTL)
      begin
         check({24'h0, ctl}, exp);
      end
   endtask : rd

   task automatic fire(input logic [2:0] k);
      kick <= k;
      @(posedge clk);
      kick <= 3'h0;
      repeat (4) @(posedge clk);
   endtask : fire

   // level outputs settle one cycle after the register, so wait two then look
   task automatic lvl(input logic sel, input logic exp);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({31'h0, sel ? evt_irq : core_irq}, {31'h0, exp});
      @(posedge clk);
   endtask : lvl

   initial
   begin
      rst_n = 1'b0;
      {psel, penable, pwrite, periph} = 4'h0;
      rise_sel = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      kick = 3'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(A_CTL, 32'h0);
      rd(A_STA, 32'h0);
      rd(A_MSK, 32'h0);
      lvl(1'b0, 1'b0);
      $display("test reset done");
      apb(1'b1, A_CTL, 32'hffff_fff8);
      rd(A_CTL, 32'h0000_00f8);
      apb(1'b0, 12'h040, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b1, A_CTL, 32'h0);
      fire(3'h7);
      rd(A_CTL, 32'h07);
      lvl(1'b0, 1'b0);
      rd(A_STA, 32'h7);
      rd(A_STA, 32'h0);
      $display("test flags done");
      // each source: enable, raise, gate off globally, clear by software
      for (int i = 0; i < 3; i++)
      begin
         ie = 8'h20 >> i;
         fl = 8'h04 >> i;
         apb(1'b1, A_CTL, {24'h0, 8'h80 | ie});
         lvl(1'b0, 1'b0);
         fire(3'h1 << i);
         rd(A_CTL, {24'h0, 8'h80 | ie | fl});
         lvl(1'b0, 1'b1);
         apb(1'b1, A_CTL, {24'h0, ie | fl});
         lvl(1'b0, 1'b0);
         apb(1'b1, A_CTL, {24'h0, 8'h80 | ie});
         rd(A_CTL, {24'h0, 8'h80 | ie});
         lvl(1'b0, 1'b0);
      end
      rise_sel <= 1'b0;
      apb(1'b1, A_CTL, 32'h0);
      fire(3'h2);
      rd(A_CTL, 32'h02);
      $display("test sources done");
      periph <= 1'b1;
      apb(1'b1, A_CTL, 32'h80);
      lvl(1'b0, 1'b0);
      apb(1'b1, A_CTL, 32'hc0);
      lvl(1'b0, 1'b1);
      apb(1'b1, A_CTL, 32'h40);
      lvl(1'b0, 1'b0);
      periph <= 1'b0;
      $display("test peripheral done");
      apb(1'b1, A_MSK, 32'h1);
      rd(A_MSK, 32'h1);
      apb(1'b0, A_STA, 32'h0);
      lvl(1'b1, 1'b0);
      fire(3'h4);
      lvl(1'b1, 1'b0);
      fire(3'h1);
      lvl(1'b1, 1'b1);
      rd(A_STA, 32'h5);
      lvl(1'b1, 1'b0);
      $display("test event status done");
      close_out();
   end
endmodule : testbench

`default_nettype wire
